// ===== rtl/cbssb_pkg.sv
package cbssb_pkg;
  // ============================================================
  // Register offsets (configuration byte addresses)
  localparam logic [7:0] OFS_SEC_STATUS  = 8'h16;
  localparam logic [7:0] OFS_PRIMARY_BUS = 8'h18;
  localparam logic [7:0] OFS_SEC_BUS     = 8'h19;
  localparam logic [7:0] OFS_SUB_BUS     = 8'h1A;
  // ============================================================
  // Status field positions
  localparam int BIT_DETECTED_PARITY = 15;
  localparam int BIT_SYSTEM_ERROR    = 14;
  localparam int BIT_MASTER_ABORT    = 13;
  localparam int BIT_RX_TARGET_ABORT = 12;
  localparam int BIT_SIG_TARGET_ABORT = 11;
  localparam int BIT_DEVSEL_LO       = 9;
  localparam int BIT_MASTER_DPAR     = 8;
  // ============================================================
  // Fixed values
  localparam logic [1:0]  DEVSEL_MEDIUM    = 2'h1;
  localparam logic [15:0] SEC_STATUS_RESET = 16'h0200;
  localparam logic [15:0] W1C_MASK         = 16'hF900;
  localparam logic [7:0]  BUS_NUM_RESET    = 8'h00;
  // ============================================================
  // Configuration cycle forwarding decision
  typedef enum logic [1:0] {
    CBSSB_FWD_NONE,
    CBSSB_FWD_TYPE0,
    CBSSB_FWD_TYPE1
  } cbssb_fwd_t;
endpackage

// ===== rtl/cbssb_regs.sv
`timescale 1ns/1ps
// How it works
// - Parity error on card side, address or data, sets bit 15 until cleared.
// - Card system error sets bit 14; bridge never drives that signal.
// - Master abort on bridge-initiated card cycle sets bit 13.
// - Target abort received on bridge-initiated card cycle sets bit 12.
// - Bridge ending a card transaction with target abort sets bit 11.
// - Bits 10..9 read-only, always 01b, medium device select timing.
// - Bit 8 sets only on parity error, bridge mastering, response enabled.
// - Bits 7 and 6 read as zero, capabilities absent.
// - Bit 5 reads zero; card clock at most 33 MHz.
// - Bits 4..0 reserved, read zero, writes ignored.
// - Status bits clear only by writing one; zero leaves them.
// - Each socket keeps its own independent status copy.
// - Host programs primary bus number, reset 00h, not used in forwarding.
// - Secondary bus number register, 8-bit read/write, resets zero.
// - Subordinate number is highest bus behind the card side.
module cbssb_regs
  import cbssb_pkg::*;
#(
  parameter int SOCKETS = 2
) (
  // Clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       rstn_i,
  // Configuration access
  input  wire logic [$clog2(SOCKETS)-1:0] cfg_func_i,
  input  wire logic [7:0]                 cfg_addr_i,
  input  wire logic                       cfg_wr_i,
  input  wire logic                       cfg_rd_i,
  input  wire logic [1:0]                 cfg_be_i,
  input  wire logic [15:0]                cfg_wdata_i,
  output logic      [15:0]                cfg_rdata_o,
  output logic                            cfg_rvalid_o,
  // Card-side event pulses, one per socket
  input  wire logic [SOCKETS-1:0]         detected_parity_error_i,
  input  wire logic [SOCKETS-1:0]         signaled_system_error_i,
  input  wire logic [SOCKETS-1:0]         received_master_abort_i,
  input  wire logic [SOCKETS-1:0]         received_target_abort_i,
  input  wire logic [SOCKETS-1:0]         signaled_target_abort_i,
  input  wire logic [SOCKETS-1:0]         card_perr_i,
  input  wire logic [SOCKETS-1:0]         bus_master_i,
  input  wire logic [SOCKETS-1:0]         parity_resp_en_i,
  // Configuration cycle forwarding
  input  wire logic                       fwd_req_i,
  input  wire logic [$clog2(SOCKETS)-1:0] fwd_func_i,
  input  wire logic [7:0]                 fwd_bus_i,
  output cbssb_fwd_t                      fwd_kind_o,
  output logic                            fwd_valid_o,
  // Card system error drive, never enabled
  output logic      [SOCKETS-1:0]         card_serr_oe_o
);

  // ============================================================
  // Elaboration check
  // One socket would leave the function select zero bits wide
  if (SOCKETS < 2) begin : g_bad_sockets
    $error("cbssb_regs: SOCKETS must be at least 2");
  end

  // ============================================================
  // State
  // Every socket function keeps a private copy
  localparam int FUNC_W = $clog2(SOCKETS);
  logic [15:0] status      [SOCKETS];
  logic [7:0]  primary_bus [SOCKETS];
  logic [7:0]  sec_bus     [SOCKETS];
  logic [7:0]  sub_bus     [SOCKETS];
  logic [15:0] next_status      [SOCKETS];
  logic [7:0]  next_primary_bus [SOCKETS];
  logic [7:0]  next_sec_bus     [SOCKETS];
  logic [7:0]  next_sub_bus     [SOCKETS];
  logic [15:0] next_rdata;
  logic        next_rvalid;
  cbssb_fwd_t  next_fwd_kind;
  logic        next_fwd_valid;
  logic [SOCKETS-1:0] next_serr_oe;

  // Socket decode, shared by writes, reads and forwarding queries
  function automatic logic func_match(input logic [FUNC_W-1:0] func, input int s);
    func_match = (func == s[FUNC_W-1:0]);
  endfunction

  // Type 0 for the card bus itself, type 1 for buses further behind it
  function automatic cbssb_fwd_t fwd_decide(input logic [7:0] bus, input logic [7:0] sec,
                                            input logic [7:0] sub);
    if (bus == sec) begin
      fwd_decide = CBSSB_FWD_TYPE0;
    end else if (bus > sec && bus <= sub) begin
      fwd_decide = CBSSB_FWD_TYPE1;
    end else begin
      fwd_decide = CBSSB_FWD_NONE;
    end
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic be,
                                            input logic [7:0] new_v);
    merge_byte = be ? new_v : old_v;
  endfunction

  // ============================================================
  // Next-state logic
  always_comb begin
    logic        hit;
    logic [15:0] clr;
    logic [15:0] set;
    hit = 1'b0;
    clr = 16'h0000;
    set = 16'h0000;
    next_serr_oe = '0;
    for (int s = 0; s < SOCKETS; s++) begin
      hit = cfg_wr_i && func_match(cfg_func_i, s);
      clr = 16'h0000;
      if (hit && cfg_addr_i == OFS_SEC_STATUS) begin
        clr = cfg_wdata_i & {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}} & W1C_MASK;
      end
      set = 16'h0000;
      set[BIT_DETECTED_PARITY]  = detected_parity_error_i[s];
      set[BIT_SYSTEM_ERROR]     = signaled_system_error_i[s];
      set[BIT_MASTER_ABORT]     = received_master_abort_i[s];
      set[BIT_RX_TARGET_ABORT]  = received_target_abort_i[s];
      set[BIT_SIG_TARGET_ABORT] = signaled_target_abort_i[s];
      set[BIT_MASTER_DPAR] = card_perr_i[s] & bus_master_i[s] & parity_resp_en_i[s];
      // Set wins so an event in the clearing cycle survives
      next_status[s] = ((status[s] & ~clr) | set) & W1C_MASK;
      next_status[s][BIT_DEVSEL_LO +: 2] = DEVSEL_MEDIUM;
      next_primary_bus[s] = primary_bus[s];
      next_sec_bus[s]     = sec_bus[s];
      next_sub_bus[s]     = sub_bus[s];
      // 16-bit lanes: offset 18h low lane primary, high lane secondary
      if (hit && cfg_addr_i == OFS_PRIMARY_BUS) begin
        next_primary_bus[s] = merge_byte(primary_bus[s], cfg_be_i[0], cfg_wdata_i[7:0]);
        next_sec_bus[s] = merge_byte(sec_bus[s], cfg_be_i[1], cfg_wdata_i[15:8]);
      end
      if (hit && cfg_addr_i == OFS_SEC_BUS) begin
        next_sec_bus[s] = merge_byte(sec_bus[s], cfg_be_i[0], cfg_wdata_i[7:0]);
      end
      if (hit && cfg_addr_i == OFS_SUB_BUS) begin
        next_sub_bus[s] = merge_byte(sub_bus[s], cfg_be_i[0], cfg_wdata_i[7:0]);
      end
    end
  end

  // ============================================================
  // Readback
  // Data stays zero between reads so a stale word never rides along
  always_comb begin
    next_rdata  = 16'h0000;
    next_rvalid = cfg_rd_i;
    for (int s = 0; s < SOCKETS; s++) begin
      if (cfg_rd_i && func_match(cfg_func_i, s)) begin
        unique case (cfg_addr_i)
          OFS_SEC_STATUS:  next_rdata = status[s];
          OFS_PRIMARY_BUS: next_rdata = {sec_bus[s], primary_bus[s]};
          OFS_SEC_BUS:     next_rdata = {8'h00, sec_bus[s]};
          OFS_SUB_BUS:     next_rdata = {8'h00, sub_bus[s]};
          default:         next_rdata = 16'h0000;
        endcase
      end
    end
  end

  // ============================================================
  // Forwarding decision
  // Primary bus is held for software only; queries arrive already on this side
  always_comb begin
    next_fwd_kind  = CBSSB_FWD_NONE;
    next_fwd_valid = fwd_req_i;
    for (int s = 0; s < SOCKETS; s++) begin
      if (fwd_req_i && func_match(fwd_func_i, s)) begin
        next_fwd_kind = fwd_decide(fwd_bus_i, sec_bus[s], sub_bus[s]);
      end
    end
  end

  // ============================================================
  // Register state
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int s = 0; s < SOCKETS; s++) begin
        status[s]      <= SEC_STATUS_RESET;
        primary_bus[s] <= BUS_NUM_RESET;
        sec_bus[s]     <= BUS_NUM_RESET;
        sub_bus[s]     <= BUS_NUM_RESET;
      end
      card_serr_oe_o <= '0;
    end else begin
      for (int s = 0; s < SOCKETS; s++) begin
        status[s]      <= next_status[s];
        primary_bus[s] <= next_primary_bus[s];
        sec_bus[s]     <= next_sec_bus[s];
        sub_bus[s]     <= next_sub_bus[s];
      end
      card_serr_oe_o <= next_serr_oe;
    end
  end

  // ============================================================
  // Readback outputs
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_rdata_o  <= 16'h0000;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rdata_o  <= next_rdata;
      cfg_rvalid_o <= next_rvalid;
    end
  end

  // ============================================================
  // Forwarding outputs
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fwd_kind_o  <= CBSSB_FWD_NONE;
      fwd_valid_o <= 1'b0;
    end else begin
      fwd_kind_o  <= next_fwd_kind;
      fwd_valid_o <= next_fwd_valid;
    end
  end

endmodule

// ===== sim/cbssb_asserts.sv
`timescale 1ns/1ps
module cbssb_asserts
  import cbssb_pkg::*;
#(
  parameter int SOCKETS = 2
) (
  input wire logic                       sys_clk_i,
  input wire logic                       rstn_i,
  input wire logic [$clog2(SOCKETS)-1:0] cfg_func_i,
  input wire logic [7:0]                 cfg_addr_i,
  input wire logic                       cfg_rd_i,
  input wire logic [15:0]                cfg_rdata_o,
  input wire logic                       cfg_rvalid_o,
  input wire logic [SOCKETS-1:0]         detected_parity_error_i,
  input wire logic [SOCKETS-1:0]         card_perr_i,
  input wire logic [SOCKETS-1:0]         bus_master_i,
  input wire logic [SOCKETS-1:0]         parity_resp_en_i,
  input wire logic                       fwd_req_i,
  input wire cbssb_fwd_t                 fwd_kind_o,
  input wire logic                       fwd_valid_o,
  input wire logic [SOCKETS-1:0]         card_serr_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_read_answered: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read not answered");
  a_devsel_fixed: assert property (cfg_rd_i && cfg_addr_i == OFS_SEC_STATUS
    |=> cfg_rdata_o[10:9] == DEVSEL_MEDIUM) else $error("devsel field wrong");
  a_low_bits_zero: assert property (cfg_rd_i && cfg_addr_i == OFS_SEC_STATUS
    |=> cfg_rdata_o[7:0] == 8'h00) else $error("low status bits not zero");
  a_parity_sets: assert property (detected_parity_error_i[0] ##2
    (cfg_rd_i && cfg_func_i == 1'b0 && cfg_addr_i == OFS_SEC_STATUS)
    |=> cfg_rdata_o[15]) else $error("parity bit not set");
  a_dpar_sets: assert property ((card_perr_i[1] && bus_master_i[1] && parity_resp_en_i[1])
    ##2 (cfg_rd_i && cfg_func_i == 1'b1 && cfg_addr_i == OFS_SEC_STATUS)
    |=> cfg_rdata_o[8]) else $error("data parity bit not set");
  a_serr_undriven: assert property (card_serr_oe_o == '0)
    else $error("system error driven");
  a_fwd_answered: assert property (fwd_req_i |=> fwd_valid_o)
    else $error("forward query not answered");
  a_fwd_idle_none: assert property (!fwd_valid_o |-> fwd_kind_o == CBSSB_FWD_NONE)
    else $error("forward kind without query");
endmodule
bind cbssb_regs cbssb_asserts #(.SOCKETS(SOCKETS)) chk_u (.sys_clk_i, .rstn_i, .cfg_func_i,
  .cfg_addr_i, .cfg_rd_i, .cfg_rdata_o, .cfg_rvalid_o, .detected_parity_error_i, .card_perr_i,
  .bus_master_i, .parity_resp_en_i, .fwd_req_i, .fwd_kind_o, .fwd_valid_o, .card_serr_oe_o);

// ===== sim/cbssb_card_model.sv
`timescale 1ns/1ps
module cbssb_card_model (
  input  wire logic       go_i,
  input  wire logic [2:0] kind_i,
  input  wire logic       sock_i,
  output logic [7:0][1:0] ev_o
);
  logic [1:0] sel;
  assign sel = go_i ? (2'b01 << sock_i) : 2'b00;
  // Kind 6 drops mastership to probe the parity qualifier
  always_comb begin
    ev_o = '0;
    if (kind_i < 3'd5) ev_o[kind_i] = sel;
    ev_o[5] = (kind_i >= 3'd5) ? sel : 2'b00;
    ev_o[6] = (kind_i == 3'd5) ? sel : 2'b00;
    ev_o[7] = ev_o[5];
  end
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
  import cbssb_pkg::*;
  logic sys_clk_i = 0, rstn_i = 0, wr = 0, rd = 0, fn = 0, go = 0, fq_req = 0, fq_fn = 0;
  logic [2:0] kind = 0;
  logic [7:0] addr = 0, fbus = 0, sec;
  logic [15:0] wdata = 0, rdata, e, qr[$];
  logic rvalid, fvalid;
  logic [1:0] serr, be = 2'h3;
  logic [7:0][1:0] ev;
  cbssb_fwd_t fkind, qf[$];
  int err_total = 0, n_tests = 0, cyc = 0;
  logic [31:0] r = 32'h0000_097e;
  initial forever #5 sys_clk_i = ~sys_clk_i;
  cbssb_card_model card_u (.go_i(go), .kind_i(kind), .sock_i(fn), .ev_o(ev));
  cbssb_regs dut_u (.sys_clk_i, .rstn_i, .cfg_func_i(fn), .cfg_addr_i(addr), .cfg_wr_i(wr),
    .cfg_rd_i(rd), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
    .cfg_rvalid_o(rvalid), .detected_parity_error_i(ev[0]), .signaled_system_error_i(ev[1]),
    .received_master_abort_i(ev[2]), .received_target_abort_i(ev[3]),
    .signaled_target_abort_i(ev[4]), .card_perr_i(ev[5]), .bus_master_i(ev[6]),
    .parity_resp_en_i(ev[7]), .fwd_req_i(fq_req), .fwd_func_i(fq_fn), .fwd_bus_i(fbus),
    .fwd_kind_o(fkind), .fwd_valid_o(fvalid), .card_serr_oe_o(serr));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task results;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk16(input logic [15:0] x, input logic [15:0] s);
    n_tests++;
    if (s !== x) begin
      err_total++;
      $display("Error rdata exp %h got %h", x, s);
    end
  endtask
  task chkf(input cbssb_fwd_t x, input cbssb_fwd_t s);
    n_tests++;
    if (s !== x) begin
      err_total++;
      $display("Error fwd_kind exp %0d got %0d", x, s);
    end
  endtask
  // Events pulse in the same cycle as an access when g is set
  task op(input bit w, rr, g, input int k, s, input logic [7:0] a, input logic [15:0] d, x);
    @(negedge sys_clk_i);
    {wr, rd, go, kind, fn, addr, wdata} = {w, rr, g, k[2:0], s[0], a, d};
    if (rr) qr.push_back(x);
    @(negedge sys_clk_i);
    {wr, rd, go} = 3'h0;
  endtask
  task fq(input int s, input logic [7:0] b, input cbssb_fwd_t x);
    @(negedge sys_clk_i);
    {fq_req, fq_fn, fbus} = {1'b1, s[0], b};
    qf.push_back(x);
    @(negedge sys_clk_i);
    fq_req = 0;
  endtask
  always @(negedge sys_clk_i) begin
    if (rvalid === 1'b1) chk16(qr.size() ? qr.pop_front() : 16'hxxxx, rdata);
    if (fvalid === 1'b1) chkf(qf.size() ? qf.pop_front() : cbssb_fwd_t'(2'h3), fkind);
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      results;
    end
  end
  initial begin
    repeat (12) @(negedge sys_clk_i);
    rstn_i = 1;
    for (int s = 0; s < 2; s++) begin
      op(0, 1, 0, 0, s, OFS_SEC_STATUS, 0, SEC_STATUS_RESET);
      op(0, 1, 0, 0, s, OFS_PRIMARY_BUS, 0, 16'h0000);
      op(0, 1, 0, 0, s, 8'h20, 0, 16'h0000);
    end
    for (int k = 0; k < 5; k++) begin
      e = 16'h0200 | (16'h0001 << (15 - k));
      op(0, 0, 1, k, 0, 0, 0, 0);
      op(0, 1, 0, 0, 0, OFS_SEC_STATUS, 0, e);
      op(0, 1, 0, 0, 1, OFS_SEC_STATUS, 0, 16'h0200);
      op(1, 0, 0, 0, 0, OFS_SEC_STATUS, 16'h0000, 0);
      op(0, 1, 0, 0, 0, OFS_SEC_STATUS, 0, e);
      op(1, 0, 0, 0, 0, OFS_SEC_STATUS, e, 0);
      op(0, 1, 0, 0, 0, OFS_SEC_STATUS, 0, 16'h0200);
    end
    op(0, 0, 1, 5, 1, 0, 0, 0);
    op(0, 1, 0, 0, 1, OFS_SEC_STATUS, 0, 16'h0300);
    op(1, 0, 0, 0, 1, OFS_SEC_STATUS, 16'hffff, 0);
    op(0, 1, 0, 0, 1, OFS_SEC_STATUS, 0, 16'h0200);
    op(0, 0, 1, 6, 1, 0, 0, 0);
    op(0, 1, 0, 0, 1, OFS_SEC_STATUS, 0, 16'h0200);
    op(1, 0, 1, 0, 0, OFS_SEC_STATUS, 16'h8000, 0);
    op(0, 1, 0, 0, 0, OFS_SEC_STATUS, 0, 16'h8200);
    // Upper lane disabled: the write-one must not reach bit 15
    be = 2'h1;
    op(1, 0, 0, 0, 0, OFS_SEC_STATUS, 16'h8000, 0);
    op(0, 1, 0, 0, 0, OFS_SEC_STATUS, 0, 16'h8200);
    be = 2'h3;
    op(1, 0, 0, 0, 0, OFS_SEC_STATUS, 16'h8000, 0);
    op(0, 1, 0, 0, 0, OFS_SEC_STATUS, 0, 16'h0200);
    repeat (4) begin
      r = lfsr(r);
      sec = {1'b0, r[14:8]};
      op(1, 0, 0, 0, 0, OFS_PRIMARY_BUS, {sec, r[7:0]}, 0);
      op(0, 1, 0, 0, 0, OFS_PRIMARY_BUS, 0, {sec, r[7:0]});
      op(1, 0, 0, 0, 0, OFS_SUB_BUS, {8'h00, sec + 8'd2}, 0);
      op(0, 1, 0, 0, 0, OFS_SEC_BUS, 0, {8'h00, sec});
      op(0, 1, 0, 0, 0, OFS_SUB_BUS, 0, {8'h00, sec + 8'd2});
      fq(0, sec, CBSSB_FWD_TYPE0);
      fq(0, sec + 8'd2, CBSSB_FWD_TYPE1);
      fq(0, sec + 8'd3, CBSSB_FWD_NONE);
      op(1, 0, 0, 0, 1, OFS_SEC_BUS, {8'h00, sec}, 0);
      fq(1, sec + 8'd1, CBSSB_FWD_NONE);
      fq(1, sec, CBSSB_FWD_TYPE0);
    end
    repeat (4) @(negedge sys_clk_i);
    // A missing answer leaves its note behind in a queue
    if (qr.size() + qf.size() != 0) begin
      err_total++;
      $display("Error pending_answers exp 0 got %0d", qr.size() + qf.size());
    end
    results;
  end
endmodule
